// [verilog/smr_regs.svh]
// Constants for the serial memory read, pause and sleep link
`ifndef SMR_REGS_SVH
`define SMR_REGS_SVH
`define SMR_OP_READ      8'h03
`define SMR_OP_SLEEP     8'hb9
`define SMR_ADDR_BITS    18
`define SMR_ADDR_TOP     18'h3ffff
`define SMR_CLK_NS       8
`define SMR_WAKE_US      450
`define SMR_WAKE_CYC     ((`SMR_WAKE_US * 1000) / `SMR_CLK_NS)
`define SMR_SCK_HALF     4
`endif

// [verilog/smr_pkg.sv]
// Types shared by both ends of the serial memory link
package smr_pkg;
  typedef enum logic [2:0] {
    SMR_D_IDLE,
    SMR_D_OPC,
    SMR_D_ADDR,
    SMR_D_DATA,
    SMR_D_SKIP,
    SMR_D_SLEEP,
    SMR_D_WAKE
  } smr_dev_st_t;
  typedef enum logic [2:0] {
    SMR_H_IDLE,
    SMR_H_SHIFT,
    SMR_H_GAP,
    SMR_H_DONE
  } smr_host_st_t;
endpackage

// [verilog/smr_link_if.sv]
// Pin-level link between the bus master and the memory device
`timescale 1ns/10ps
interface smr_link_if;
  logic sel_b;
  logic sck;
  logic mosi;
  logic pause_b;
  logic miso_o;
  logic miso_oe;
  wire  miso;
  // A released line shows the opposite level, so a silent device is noticed
  assign miso = miso_oe ? miso_o : ~miso_o;
  modport dev  (input sel_b, input sck, input mosi, input pause_b,
                output miso_o, output miso_oe);
  modport host (output sel_b, output sck, output mosi, output pause_b,
                input miso);
endinterface

// [verilog/smr_dev.sv]
// Device end: read command, pause and sleep with wake-up recovery
// Notes on behaviour
// [RQ1] Opcode then three address bytes start read
// [RQ2] Data input ignored after address until end
// [RQ3] Eight clocks per byte, MSB first
// [RQ4] Address increments per byte, wraps to zero
// [RQ5] Select rising ends read; new opcode needed
// [RQ6] Pause low with clock low suspends
// [RQ7] Pause high with clock low resumes
// [RQ8] Master changes pause only with clock low
// [RQ9] Sleep opcode then select rising sleeps
// [RQ10] Asleep: clock, data ignored, output off
// [RQ11] Select falling wakes within recovery time
// [RQ12] Output off, opcodes ignored during wake-up
// [RQ13] Master may send dummy read, then wait
// [RQ14] Read opcode is byte value three
// [RQ15] Upper six address bits are ignored
// [RQ16] Output off when not returning data
`timescale 1ns/10ps
`include "smr_regs.svh"
module smr_dev #(
  parameter int unsigned WAKE_CYC = `SMR_WAKE_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  smr_link_if.dev          link,
  input  wire logic [7:0]  mem_rdata_in,
  output logic      [17:0] mem_addr_out,
  output logic             asleep_out,
  output logic             waking_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]          sel_s;
    logic [2:0]          sck_s;
    logic [2:0]          mosi_s;
    logic [2:0]          pause_s;
    logic                sel_b;
    logic                sck;
    logic                pause_b;
    smr_pkg::smr_dev_st_t st;
    logic [2:0]          bit_cnt;
    logic [1:0]          byte_cnt;
    logic [7:0]          sh;
    logic [17:0]         addr;
    logic [7:0]          dout;
    logic                oe;
    logic                sleep_req;
    logic [19:0]         wake_cnt;
  } smr_dev_s_t;
  smr_dev_s_t s_q;
  smr_dev_s_t s_d;
  logic sel_new;
  logic sck_new;
  logic pause_new;
  logic sck_rise;
  logic sck_fall;
  logic sel_fall;
  logic sel_rise;
  logic active;
  // ----------------------------------------------------------------
  // Edge detection on filtered pins
  // ----------------------------------------------------------------
  // Select, clock and pause change only when stages two and three agree, against glitches
  always_comb
  begin
    sel_new   = (s_q.sel_s[1] == s_q.sel_s[2]) ? s_q.sel_s[2] : s_q.sel_b;
    sck_new   = (s_q.sck_s[1] == s_q.sck_s[2]) ? s_q.sck_s[2] : s_q.sck;
    pause_new = (s_q.pause_s[1] == s_q.pause_s[2]) ? s_q.pause_s[2] : s_q.pause_b;
    sel_fall  = s_q.sel_b & ~sel_new;
    sel_rise  = ~s_q.sel_b & sel_new;
    // Pause only changes while the clock is low, so it gates edges
    active    = ~s_q.sel_b & s_q.pause_b;                         // RQ6 RQ7 RQ8
    sck_rise  = active & ~s_q.sck & sck_new;
    sck_fall  = active & s_q.sck & ~sck_new;
  end
  // ----------------------------------------------------------------
  // Protocol machine
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d          = s_q;
    s_d.sel_s    = {s_q.sel_s[1:0], link.sel_b};
    s_d.sck_s    = {s_q.sck_s[1:0], link.sck};
    s_d.mosi_s   = {s_q.mosi_s[1:0], link.mosi};
    s_d.pause_s  = {s_q.pause_s[1:0], link.pause_b};
    s_d.sel_b    = sel_new;
    s_d.sck      = sck_new;
    // Pause level taken only while clock low; a pause change with clock high waits for clock low
    if (~s_q.sck)
      s_d.pause_b = pause_new;                                    // RQ6 RQ7
    case (s_q.st)
      smr_pkg::SMR_D_IDLE:
      begin
        s_d.oe = 1'b0;                                            // RQ16
        if (sel_fall)
        begin
          s_d.st       = smr_pkg::SMR_D_OPC;
          s_d.bit_cnt  = 3'h0;
          s_d.byte_cnt = 2'h0;
        end
      end
      smr_pkg::SMR_D_OPC,
      smr_pkg::SMR_D_ADDR:
      begin
        if (sck_rise)
        begin
          s_d.sh      = {s_q.sh[6:0], s_q.mosi_s[2]};
          s_d.bit_cnt = s_q.bit_cnt + 3'h1;
          if (s_q.bit_cnt == 3'h7)
          begin
            if (s_q.st == smr_pkg::SMR_D_OPC)
            begin
              if (s_d.sh == `SMR_OP_READ)                         // RQ14 RQ1
                s_d.st = smr_pkg::SMR_D_ADDR;
              else
              begin
                s_d.sleep_req = (s_d.sh == `SMR_OP_SLEEP);        // RQ9
                s_d.st        = smr_pkg::SMR_D_SKIP;
              end
            end
            else
            begin
              // Upper six bits of the first byte fall off the 18-bit field
              s_d.addr     = {s_q.addr[9:0], s_d.sh};             // RQ1 RQ15
              s_d.byte_cnt = s_q.byte_cnt + 2'h1;
              if (s_q.byte_cnt == 2'h2)
                s_d.st = smr_pkg::SMR_D_DATA;                     // RQ2
            end
          end
        end
      end
      smr_pkg::SMR_D_DATA:
      begin
        // Data input no longer read here
        if (sck_fall)                                             // RQ2 RQ3
        begin
          s_d.oe = 1'b1;
          if (s_q.bit_cnt == 3'h0)
            s_d.dout = mem_rdata_in;
          else
            s_d.dout = {s_q.dout[6:0], 1'b0};                     // RQ3
        end
        if (sck_rise)
        begin
          s_d.bit_cnt = s_q.bit_cnt + 3'h1;
          if (s_q.bit_cnt == 3'h7)
            s_d.addr = (s_q.addr == `SMR_ADDR_TOP) ? 18'h00000 :  // RQ4
                       s_q.addr + 18'h00001;
        end
      end
      smr_pkg::SMR_D_SKIP:
        s_d.oe = 1'b0;
      smr_pkg::SMR_D_SLEEP:
      begin
        s_d.oe = 1'b0;                                            // RQ10
        if (sel_fall)
        begin
          s_d.st       = smr_pkg::SMR_D_WAKE;                     // RQ11
          s_d.wake_cnt = 20'h00000;
        end
      end
      smr_pkg::SMR_D_WAKE:
      begin
        s_d.oe       = 1'b0;                                      // RQ12
        s_d.wake_cnt = s_q.wake_cnt + 20'h00001;
        if (s_q.wake_cnt >= 20'(WAKE_CYC - 1))                    // RQ11
          s_d.st = s_q.sel_b ? smr_pkg::SMR_D_IDLE : smr_pkg::SMR_D_SKIP;
      end
      default:
        s_d.st = smr_pkg::SMR_D_IDLE;
    endcase
    // Select rising ends any transfer except in sleep or wake-up; a pause does not block it
    if (sel_rise && s_q.st != smr_pkg::SMR_D_SLEEP && s_q.st != smr_pkg::SMR_D_WAKE)
    begin
      s_d.oe        = 1'b0;                                       // RQ5 RQ16
      s_d.sleep_req = 1'b0;
      s_d.st        = s_q.sleep_req ? smr_pkg::SMR_D_SLEEP : smr_pkg::SMR_D_IDLE;
    end
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_q         <= '0;
      s_q.sel_s   <= 3'h7;
      s_q.pause_s <= 3'h7;
      s_q.sel_b   <= 1'b1;
      s_q.pause_b <= 1'b1;
      s_q.st      <= smr_pkg::SMR_D_IDLE;
    end
    else
      s_q <= s_d;
  end
  // Output enable also drops while paused
  assign link.miso_o   = s_q.dout[7];
  assign link.miso_oe  = s_q.oe & ~s_q.sel_b & s_q.pause_b;       // RQ16
  assign mem_addr_out  = s_q.addr;
  assign asleep_out    = (s_q.st == smr_pkg::SMR_D_SLEEP);
  assign waking_out    = (s_q.st == smr_pkg::SMR_D_WAKE);
endmodule

// [verilog/smr_host.sv]
// Master end: drives select, clock, data and pause; collects read bytes
`timescale 1ns/10ps
`include "smr_regs.svh"
module smr_host (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  smr_link_if.host         link,
  input  wire logic        start_in,
  input  wire logic [7:0]  opcode_in,
  input  wire logic [17:0] addr_in,
  input  wire logic [7:0]  nbytes_in,
  input  wire logic        pause_req_in,
  output logic             busy_out,
  output logic             rdata_valid_out,
  output logic      [7:0]  rdata_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    smr_pkg::smr_host_st_t st;
    logic [2:0]  miso_s;
    logic [2:0]  div;
    logic        sck;
    logic        sel_b;
    logic        pause_b;
    logic [31:0] tx;
    logic [5:0]  bits_left;
    logic [2:0]  rx_cnt;
    logic [7:0]  rx;
    logic [7:0]  bytes_left;
    logic        is_read;
    logic        vld;
    logic [7:0]  rdata;
  } smr_host_s_t;
  smr_host_s_t s_q;
  smr_host_s_t s_d;
  // ----------------------------------------------------------------
  // Transfer machine; clock divided from the system clock
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d        = s_q;
    s_d.miso_s = {s_q.miso_s[1:0], link.miso};
    s_d.vld    = 1'b0;
    case (s_q.st)
      smr_pkg::SMR_H_IDLE:
      begin
        s_d.sck   = 1'b0;
        s_d.sel_b = 1'b1;
        if (start_in)
        begin
          // Opcode then 24 address bits, upper six sent as zero
          s_d.is_read    = (opcode_in == `SMR_OP_READ);           // RQ14
          s_d.tx         = {opcode_in, 6'h00, addr_in};           // RQ1
          s_d.bits_left  = s_d.is_read ? 6'd32 : 6'd8;
          s_d.bytes_left = nbytes_in;
          s_d.rx_cnt     = 3'h0;
          s_d.sel_b      = 1'b0;
          s_d.div        = 3'h0;
          s_d.st         = smr_pkg::SMR_H_SHIFT;
        end
      end
      smr_pkg::SMR_H_SHIFT:
      begin
        // Pause changes only while the clock is low
        if (!s_q.sck)
          s_d.pause_b = ~pause_req_in;                            // RQ8
        if (s_q.pause_b && !(s_q.sck == 1'b0 && pause_req_in))
        begin
          s_d.div = s_q.div + 3'h1;
          if (s_q.div == 3'(`SMR_SCK_HALF - 1))
          begin
            s_d.div = 3'h0;
            s_d.sck = ~s_q.sck;
            if (s_q.sck)
            begin
              if (s_q.bits_left != 6'd0)
              begin
                s_d.tx        = {s_q.tx[30:0], 1'b0};
                s_d.bits_left = s_q.bits_left - 6'd1;
              end
              else
              begin
                // Sample at the end of the high phase, MSB first: the round
                // trip through both pin filters is longer than half a period
                s_d.rx     = {s_q.rx[6:0], s_q.miso_s[2]};        // RQ3
                s_d.rx_cnt = s_q.rx_cnt + 3'h1;
                if (s_q.rx_cnt == 3'h7)
                begin
                  s_d.vld        = 1'b1;
                  s_d.rdata      = {s_q.rx[6:0], s_q.miso_s[2]};
                  s_d.bytes_left = s_q.bytes_left - 8'h01;
                end
              end
              if ((s_q.bits_left == 6'd1 && !s_q.is_read) ||
                  (s_q.bits_left == 6'd0 && s_q.rx_cnt == 3'h7 &&
                   s_q.bytes_left <= 8'h01))
              begin
                s_d.sck = 1'b0;
                s_d.st  = smr_pkg::SMR_H_GAP;
              end
            end
          end
        end
        else if (!s_q.pause_b)
          // Restart the low phase after a pause so the device drives again first
          s_d.div = 3'h0;                                         // RQ8
      end
      smr_pkg::SMR_H_GAP:
      begin
        s_d.pause_b = 1'b1;
        s_d.sel_b   = 1'b1;                                       // RQ5
        s_d.div     = s_q.div + 3'h1;
        if (s_q.div == 3'h7)
          s_d.st = smr_pkg::SMR_H_DONE;
      end
      smr_pkg::SMR_H_DONE:
        s_d.st = smr_pkg::SMR_H_IDLE;
      default:
        s_d.st = smr_pkg::SMR_H_IDLE;
    endcase
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_q         <= '0;
      s_q.sel_b   <= 1'b1;
      s_q.pause_b <= 1'b1;
      s_q.st      <= smr_pkg::SMR_H_IDLE;
    end
    else
      s_q <= s_d;
  end
  assign link.sel_b      = s_q.sel_b;
  assign link.sck        = s_q.sck;
  assign link.mosi       = s_q.tx[31];
  assign link.pause_b    = s_q.pause_b;
  assign busy_out        = (s_q.st != smr_pkg::SMR_H_IDLE);
  assign rdata_valid_out = s_q.vld;
  assign rdata_out       = s_q.rdata;
endmodule

// [bench/smr_link_monitor.sv]
// Checker on the pins between the bus master and the memory device
`timescale 1ns/10ps
module smr_link_monitor (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic sel_b,
  input wire logic sck,
  input wire logic mosi,
  input wire logic pause_b,
  input wire logic miso_o,
  input wire logic miso_oe
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // ----------------------------------------
  // Helper: serial clock rises in this frame
  // ----------------------------------------
  logic [15:0] rise_cnt_q;
  // Cleared while deselected so each frame counts from zero
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      rise_cnt_q <= 16'h0000;
    else if (sel_b)
      rise_cnt_q <= 16'h0000;
    else if ($rose(sck))
      rise_cnt_q <= rise_cnt_q + 16'h0001;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Output only after opcode and three address bytes are in
  oe_late_a: assert property ($rose(miso_oe) |-> rise_cnt_q >= 16'h0020)
    else $error("data output enabled before the address was complete");
  sel_lead_a: assert property ($fell(sel_b) |-> !sck [*3])
    else $error("serial clock rose too soon after select fell");
  sck_half_a: assert property ($rose(sck) |-> sck [*4])
    else $error("serial clock high phase too short");
  mosi_stable_a: assert property (sck |-> $stable(mosi))
    else $error("data input moved while serial clock high");
  sck_idle_a: assert property (sel_b |-> !sck)
    else $error("serial clock high while deselected");
  sel_gap_a: assert property ($rose(sel_b) |-> sel_b [*8])
    else $error("select gap shorter than eight cycles");
  sel_high_off_a: assert property (sel_b [*5] |-> !miso_oe)
    else $error("data output driven while deselected");
  pause_low_sck_a: assert property ($changed(pause_b) |-> !sck)
    else $error("pause changed while serial clock high");
  pause_off_a: assert property (!pause_b [*5] |-> !miso_oe)
    else $error("data output driven while paused");
  // Main scenarios reached
  data_seen_c: cover property ($rose(miso_oe));
  pause_seen_c: cover property ($fell(pause_b) ##1 !sel_b);
  frame_end_c: cover property ($rose(sel_b));
endmodule

// [bench/tb_serial_memory_read_hold_sleep.sv]
// Testbench: master and device ends joined back to back
`timescale 1ns/10ps
`include "smr_regs.svh"
module tb_serial_memory_read_hold_sleep;
  logic        sys_clk_in;
  logic        rst_b_in;
  logic        start_in;
  logic [7:0]  opcode_in;
  logic [17:0] addr_in;
  logic [7:0]  nbytes_in;
  logic        pause_req_in;
  logic        busy_out;
  logic        rdata_valid_out;
  logic [7:0]  rdata_out;
  logic [17:0] mem_addr_out;
  logic        asleep_out;
  logic        waking_out;
  int          err_count;
  int          checked;
  // Memory contents: a fixed function of the address, so wrap shows up
  wire [7:0] mem_rdata = mem_addr_out[7:0] ^ {2'h0, mem_addr_out[17:12]};
  smr_link_if link ();
  // Short wake-up keeps the run brief
  smr_dev #(.WAKE_CYC(50)) u_smr_dev (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .link(link), .mem_rdata_in(mem_rdata), .mem_addr_out(mem_addr_out),
    .asleep_out(asleep_out), .waking_out(waking_out));
  smr_host u_smr_host (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .link(link),
    .start_in(start_in), .opcode_in(opcode_in), .addr_in(addr_in), .nbytes_in(nbytes_in),
    .pause_req_in(pause_req_in), .busy_out(busy_out), .rdata_valid_out(rdata_valid_out),
    .rdata_out(rdata_out));
  smr_link_monitor u_smr_link_monitor (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .sel_b(link.sel_b), .sck(link.sck), .mosi(link.mosi), .pause_b(link.pause_b),
    .miso_o(link.miso_o), .miso_oe(link.miso_oe));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [7:0] exp_byte(input logic [17:0] a);
    return a[7:0] ^ {2'h0, a[17:12]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs always move 1 ns after the edge, clear of the sampling point
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 1000 && busy_out !== 1'b0; i++)
      tick(1);
    check(busy_out, 1'b0);
  endtask
  task automatic start_op(input logic [7:0] op, input logic [17:0] a, input logic [7:0] n);
    wait_idle();
    start_in = 1'b1;
    opcode_in = op;
    addr_in = a;
    nbytes_in = n;
    tick(1);
    start_in = 1'b0;
  endtask
  // Bounded wait for one byte; the pulse lasts one cycle
  task automatic get_byte(output logic [7:0] b);
    for (int i = 0; i < 400 && rdata_valid_out !== 1'b1; i++)
      tick(1);
    check(rdata_valid_out, 1'b1);
    b = rdata_out;
    tick(1);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_wrap;
    logic [7:0] b;
    start_op(`SMR_OP_READ, 18'h3fffe, 8'h03);
    for (int k = 0; k < 3; k++)
    begin
      get_byte(b);
      check(b, exp_byte(18'(18'h3fffe + k)));
    end
    // Back to back: the next read needs its own opcode
    start_op(`SMR_OP_READ, 18'h00123, 8'h01);
    get_byte(b);
    check(b, exp_byte(18'h00123));
    $display("test_wrap done");
  endtask
  task automatic test_pause;
    logic [7:0] b;
    start_op(`SMR_OP_READ, 18'h01230, 8'h02);
    get_byte(b);
    check(b, exp_byte(18'h01230));
    pause_req_in = 1'b1;
    tick(40);
    check(link.miso_oe, 1'b0);
    pause_req_in = 1'b0;
    get_byte(b);
    check(b, exp_byte(18'h01231));
    $display("test_pause done");
  endtask
  task automatic test_sleep;
    logic [7:0] b;
    start_op(`SMR_OP_SLEEP, 18'h00000, 8'h01);
    wait_idle();
    tick(8);
    check(asleep_out, 1'b1);
    check(link.miso_oe, 1'b0);
    // Throwaway read starts the wake-up
    start_op(`SMR_OP_READ, 18'h00000, 8'h01);
    tick(8);
    check(waking_out, 1'b1);
    check(link.miso_oe, 1'b0);
    get_byte(b);
    check(link.miso_oe, 1'b0);
    check({asleep_out, waking_out}, 2'h0);
    start_op(`SMR_OP_READ, 18'h3ffff, 8'h01);
    get_byte(b);
    check(b, exp_byte(18'h3ffff));
    $display("test_sleep done");
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------
  initial
  begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    err_count = 0;
    checked = 0;
    rst_b_in = 1'b0;
    start_in = 1'b0;
    opcode_in = 8'h00;
    addr_in = 18'h00000;
    nbytes_in = 8'h00;
    pause_req_in = 1'b0;
    tick(2);
    rst_b_in = 1'b1;
    test_wrap();
    test_pause();
    test_sleep();
    finish_test();
  end
  // Whole run needs about 2000 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    err_count++;
    finish_test();
  end
endmodule
